// ===== hdl/dcc_map.svh
//------------------
// Behaviour
// - Size field picks byte/word/long/16-byte unit
// - Auto bit picks internal or pin requests
// - Ack phase or direction bit steers ack in dual, direction in single
// - Polarity bit sets ack active level
// - Request sensed by level or edge, polarity
// - Burst bit picks cycle-steal or burst
// - Address mode bit picks dual or single
// - Enabled end flag raises end interrupt
// - Count reaching zero sets end flag
// - Aborted transfer leaves end flag clear
// - End flag clears by read-1 then write-0
// - Set end flag blocks any new start
// - Auto mode starts when both enables set
// - Pin mode starts on request when enabled
// - Clearing channel enable halts the transfer
// - Control cleared by reset and standby
// - Vector register low byte only, rest zero
// - Vector register survives reset and standby
// - Vector number offered with end interrupt
// - Count register shows transfers still remaining
//------------------
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// Register offsets, byte addresses
`define DCC_CTRL0_OFS 8'h00
`define DCC_VEC0_OFS 8'h04
`define DCC_CNT0_OFS 8'h08
`define DCC_CTRL1_OFS 8'h10
`define DCC_VEC1_OFS 8'h14
`define DCC_CNT1_OFS 8'h18
`define DCC_OPER_OFS 8'h20

// Channel control field positions
`define DCC_TE_BIT 1
`define DCC_CTRL_W 16
`define DCC_CTRL_RST 16'h0000

// Operation register field positions
`define DCC_DME_BIT 0
`define DCC_NMI_BIT 1
`define DCC_AE_BIT 2

// Transfer size codes and beat counts minus one
`define DCC_TS_16B 2'h3
`define DCC_BEATS_16B 2'h3
`define DCC_CNT_W 24
`define DCC_CNT_ONE 24'h000001
`define DCC_VEC_W 8

`endif

// ===== hdl/dcc_pkg.sv
package dcc_pkg;

    // Channel control layout, bit 15 down to bit 0
    typedef struct packed {
        logic [1:0] dst_mode;
        logic [1:0] src_mode;
        logic [1:0] transfer_size;
        logic auto_request_select;
        logic ack_cycle_or_direction;
        logic ack_polarity;
        logic request_detect_edge;
        logic request_detect_high;
        logic bus_burst_mode;
        logic address_mode_single;
        logic interrupt_enable;
        logic transfer_end_flag;
        logic channel_enable;
    } dcc_ctrl_t;

    // Engine phases of one beat
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } dcc_state_t;

endpackage : dcc_pkg

// ===== hdl/dcc_top.sv
`timescale 1ns/1ps
`include "dcc_map.svh"

module dcc_top
    import dcc_pkg::*;
#(
    parameter int NCH = 2 // Channel count
) (
    input wire logic clk, // 10 MHz system clock
    input wire logic reset_n, // Synchronous reset, active low
    input wire logic standby_i, // Standby entry, clears control
    input wire logic [7:0] addr_i, // Register byte address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [31:0] rdata_o, // Read data, cycle after strobe
    input wire logic nmi_i, // NMI abort event, same clock
    input wire logic addr_err_i, // Address error event, same clock
    input wire logic [NCH-1:0] transfer_request_in, // Request pins
    output logic [NCH-1:0] transfer_ack, // Ack pins, programmable level
    output logic [NCH-1:0] xfer_dev_to_mem_o, // Single mode direction
    output logic [NCH-1:0] busy_o, // Channel owns a transfer
    output logic [NCH-1:0] transfer_end_irq, // End interrupt request
    output logic [NCH-1:0][7:0] irq_vector_number // Vector offered
);

    //------------------
    // Declarations
    //------------------
    dcc_ctrl_t ctrl_r [NCH]; // Channel control
    logic [`DCC_VEC_W-1:0] vec_r [NCH]; // Vector, never reset
    logic [`DCC_CNT_W-1:0] cnt_r [NCH]; // Remaining count
    dcc_state_t st_r [NCH]; // Engine phase
    dcc_state_t st_nxt [NCH]; // Next engine phase
    logic [1:0] beat_r [NCH]; // Beat within a 16-byte unit
    logic [1:0] beat_nxt [NCH]; // Next beat
    logic [NCH-1:0] burst_r; // Pin-request burst run in progress
    logic [NCH-1:0] pend_r; // Latched request edge
    logic [NCH-1:0] te_seen_r; // End flag was read as 1
    logic [NCH-1:0] req_s1_r; // Synchroniser stage 1
    logic [NCH-1:0] req_s2_r; // Synchroniser stage 2
    logic [NCH-1:0] req_s3_r; // Previous stage 2, for edges
    logic dme_r; // Global enable
    logic nmi_r; // NMI abort flag
    logic ae_r; // Address error flag
    logic nmi_seen_r; // NMI flag read as 1
    logic ae_seen_r; // Error flag read as 1
    logic [NCH-1:0] ok; // Channel may run
    logic [NCH-1:0] req; // Channel has a request
    logic [NCH-1:0] beat_end; // Beat completes this cycle
    logic [NCH-1:0] last_xfer; // Final count consumed
    logic [NCH-1:0] start; // Unit starts from idle
    logic [NCH-1:0] edge_hit; // Programmed edge seen
    logic [31:0] rd_mux; // Read data before the flop

    //------------------
    // Functions
    //------------------
    // Ack is active in the phase chosen by the mode bits
    function automatic logic ack_phase(dcc_state_t st, dcc_ctrl_t c);
        logic act;
        act = 1'b0;
        if (c.address_mode_single) begin
            act = (st == ST_WRITE); // Single: one bus cycle
        end else if (c.ack_cycle_or_direction) begin
            act = (st == ST_WRITE); // Dual: ack in write cycle
        end else begin
            act = (st == ST_READ); // Dual: ack in read cycle
        end
        return act;
    endfunction : ack_phase

    // Beats per unit minus one; 16-byte is four longwords
    function automatic logic [1:0] last_beat(dcc_ctrl_t c);
        return (c.transfer_size == `DCC_TS_16B) ? `DCC_BEATS_16B : 2'h0;
    endfunction : last_beat

    // First phase of a beat depends on address mode
    function automatic dcc_state_t first_phase(dcc_ctrl_t c);
        return c.address_mode_single ? ST_WRITE : ST_READ;
    endfunction : first_phase

    // Read-1-then-write-0 flag clear; set wins over clear
    function automatic logic flag_nxt(logic f, logic set, logic seen, logic wr, logic wb);
        logic n;
        n = f;
        if (wr && !wb && seen) begin // Writes of 1 are ignored
            n = 1'b0;
        end
        if (set) begin
            n = 1'b1;
        end
        return n;
    endfunction : flag_nxt

    //------------------
    // Request synchroniser
    //------------------
    // Pins are asynchronous; only stage 2 onward is looked at
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_s1_r <= '0;
            req_s2_r <= '0;
            req_s3_r <= '0;
        end else begin
            req_s1_r <= transfer_request_in;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    //------------------
    // Request qualification
    //------------------
    // Start gate, edge detect and request choice per channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            // Both enables, no abort flags, no end flag
            ok[i] = ctrl_r[i].channel_enable && dme_r && !nmi_r && !ae_r
                    && !ctrl_r[i].transfer_end_flag;
            if (ctrl_r[i].request_detect_high) begin
                edge_hit[i] = req_s2_r[i] && !req_s3_r[i]; // Rising
            end else begin
                edge_hit[i] = !req_s2_r[i] && req_s3_r[i]; // Falling
            end
            if (ctrl_r[i].auto_request_select) begin
                req[i] = 1'b1; // Internally generated
            end else if (burst_r[i]) begin
                req[i] = 1'b1; // Burst keeps the bus
            end else if (ctrl_r[i].request_detect_edge) begin
                req[i] = pend_r[i];
            end else begin
                req[i] = (req_s2_r[i] == ctrl_r[i].request_detect_high);
            end
        end
    end

    //------------------
    // Engine next state
    //------------------
    // A beat is read+write in dual mode, one write in single
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            st_nxt[i] = st_r[i];
            beat_nxt[i] = beat_r[i];
            start[i] = 1'b0;
            beat_end[i] = ok[i] && (st_r[i] == ST_WRITE);
            last_xfer[i] = beat_end[i] && (cnt_r[i] == `DCC_CNT_ONE);
            unique case (st_r[i])
                ST_IDLE: begin
                    if (ok[i] && req[i]) begin
                        start[i] = 1'b1;
                        st_nxt[i] = first_phase(ctrl_r[i]);
                        beat_nxt[i] = 2'h0;
                    end
                end
                ST_READ: begin
                    // Halted enables end the run without a flag
                    st_nxt[i] = ok[i] ? ST_WRITE : ST_IDLE;
                end
                ST_WRITE: begin
                    if (!ok[i] || last_xfer[i]) begin
                        st_nxt[i] = ST_IDLE;
                    end else if (beat_r[i] != last_beat(ctrl_r[i])) begin
                        st_nxt[i] = first_phase(ctrl_r[i]);
                        beat_nxt[i] = beat_r[i] + 2'h1;
                    end else if (burst_r[i] || ctrl_r[i].auto_request_select) begin
                        // Burst-mode runs go on without idling; auto cycle-steal runs idle a cycle
                        st_nxt[i] = ctrl_r[i].bus_burst_mode ? first_phase(ctrl_r[i])
                                                             : ST_IDLE;
                        beat_nxt[i] = 2'h0;
                    end else begin
                        st_nxt[i] = ST_IDLE; // Cycle steal frees the bus
                    end
                end
                default: begin
                    st_nxt[i] = ST_IDLE; // Unused code recovers
                end
            endcase
        end
    end

    //------------------
    // Engine state
    //------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                st_r[i] <= ST_IDLE;
                beat_r[i] <= 2'h0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                st_r[i] <= st_nxt[i];
                beat_r[i] <= beat_nxt[i];
            end
        end
    end

    //------------------
    // Edge latch and burst hold
    //------------------
    // An edge seen while one is being consumed is kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_r <= '0;
            burst_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (edge_hit[i] && ctrl_r[i].request_detect_edge) begin
                    pend_r[i] <= 1'b1;
                end else if (start[i] || !ctrl_r[i].channel_enable) begin
                    pend_r[i] <= 1'b0;
                end
                if (st_nxt[i] == ST_IDLE) begin
                    burst_r[i] <= 1'b0;
                end else if (start[i] && ctrl_r[i].bus_burst_mode) begin
                    burst_r[i] <= !ctrl_r[i].auto_request_select;
                end
            end
        end
    end

    //------------------
    // Transfer count
    //------------------
    // Software write wins; zero stands for the full range
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                cnt_r[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (wr_i && addr_i == (i == 0 ? `DCC_CNT0_OFS : `DCC_CNT1_OFS)) begin
                    cnt_r[i] <= wdata_i[`DCC_CNT_W-1:0];
                end else if (beat_end[i]) begin
                    cnt_r[i] <= cnt_r[i] - `DCC_CNT_ONE;
                end
            end
        end
    end

    //------------------
    // Channel control registers
    //------------------
    // Cleared by reset and standby; held otherwise
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_r[i] <= `DCC_CTRL_RST;
            end
            te_seen_r <= '0;
        end else if (standby_i) begin
            for (int i = 0; i < NCH; i++) begin
                ctrl_r[i] <= `DCC_CTRL_RST;
            end
            te_seen_r <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                logic hit;
                hit = (addr_i == (i == 0 ? `DCC_CTRL0_OFS : `DCC_CTRL1_OFS));
                if (wr_i && hit) begin
                    ctrl_r[i] <= dcc_ctrl_t'(wdata_i[`DCC_CTRL_W-1:0]);
                end
                // End flag keeps its own path
                ctrl_r[i].transfer_end_flag <= flag_nxt(ctrl_r[i].transfer_end_flag,
                    last_xfer[i], te_seen_r[i], wr_i && hit,
                    wdata_i[`DCC_TE_BIT]);
                if (rd_i && hit && ctrl_r[i].transfer_end_flag) begin
                    te_seen_r[i] <= 1'b1;
                end else if (wr_i && hit) begin
                    te_seen_r[i] <= 1'b0;
                end
            end
        end
    end

    //------------------
    // Vector registers
    //------------------
    // No reset here: contents survive reset and standby
    always_ff @(posedge clk) begin
        for (int i = 0; i < NCH; i++) begin
            if (wr_i && addr_i == (i == 0 ? `DCC_VEC0_OFS : `DCC_VEC1_OFS)) begin
                vec_r[i] <= wdata_i[`DCC_VEC_W-1:0];
            end
        end
    end

    //------------------
    // Operation register
    //------------------
    // Abort flags set by events, cleared like the end flag
    always_ff @(posedge clk) begin
        if (!reset_n || standby_i) begin
            dme_r <= 1'b0;
            nmi_r <= 1'b0;
            ae_r <= 1'b0;
            nmi_seen_r <= 1'b0;
            ae_seen_r <= 1'b0;
        end else begin
            logic hit;
            hit = (addr_i == `DCC_OPER_OFS);
            if (wr_i && hit) begin
                dme_r <= wdata_i[`DCC_DME_BIT];
            end
            nmi_r <= flag_nxt(nmi_r, nmi_i, nmi_seen_r, wr_i && hit,
                              wdata_i[`DCC_NMI_BIT]);
            ae_r <= flag_nxt(ae_r, addr_err_i, ae_seen_r, wr_i && hit,
                             wdata_i[`DCC_AE_BIT]);
            if (rd_i && hit) begin
                nmi_seen_r <= nmi_r;
                ae_seen_r <= ae_r;
            end else if (wr_i && hit) begin
                nmi_seen_r <= 1'b0;
                ae_seen_r <= 1'b0;
            end
        end
    end

    //------------------
    // Read path
    //------------------
    // Unmapped addresses read zero; reserved bits read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_i)
            `DCC_CTRL0_OFS: rd_mux = {16'h0000, ctrl_r[0]};
            `DCC_VEC0_OFS: rd_mux = {24'h00_0000, vec_r[0]};
            `DCC_CNT0_OFS: rd_mux = {8'h00, cnt_r[0]};
            `DCC_CTRL1_OFS: rd_mux = {16'h0000, ctrl_r[NCH-1]};
            `DCC_VEC1_OFS: rd_mux = {24'h00_0000, vec_r[NCH-1]};
            `DCC_CNT1_OFS: rd_mux = {8'h00, cnt_r[NCH-1]};
            `DCC_OPER_OFS: rd_mux = {29'h0, ae_r, nmi_r, dme_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Data stand only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    //------------------
    // Pin and status outputs
    //------------------
    // Ack follows the next phase so the flop lines up with it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            transfer_ack <= '1; // Reset polarity is active low
            xfer_dev_to_mem_o <= '0;
            busy_o <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                // Polarity 0 drives low when active
                transfer_ack[i] <= ack_phase(st_nxt[i], ctrl_r[i])
                                   ~^ ctrl_r[i].ack_polarity;
                xfer_dev_to_mem_o[i] <= ctrl_r[i].address_mode_single
                                        && ctrl_r[i].ack_cycle_or_direction;
                busy_o[i] <= (st_nxt[i] != ST_IDLE);
            end
        end
    end

    //------------------
    // End interrupt and vector
    //------------------
    // Level request while flag and enable both hold
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            transfer_end_irq <= '0;
            irq_vector_number <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                transfer_end_irq[i] <= ctrl_r[i].transfer_end_flag
                                       && ctrl_r[i].interrupt_enable;
                if (ctrl_r[i].transfer_end_flag && ctrl_r[i].interrupt_enable) begin
                    irq_vector_number[i] <= vec_r[i];
                end else begin
                    irq_vector_number[i] <= 8'h00;
                end
            end
        end
    end

endmodule : dcc_top

// ===== tb/dcc_assertions.sv
`timescale 1ns/1ps
module dcc_checker
    import dcc_pkg::*;
#(
    parameter int NCH = 2 // Channel count
) (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic standby_i, // Standby entry
    input wire logic [7:0] addr_i, // Address
    input wire logic [31:0] wdata_i, // Write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    input wire logic [31:0] rdata_o, // Read data
    input wire logic nmi_i, // Abort event
    input wire logic addr_err_i, // Error event
    input wire logic [NCH-1:0] transfer_request_in, // Requests
    input wire logic [NCH-1:0] transfer_ack, // Acks
    input wire logic [NCH-1:0] xfer_dev_to_mem_o, // Direction
    input wire logic [NCH-1:0] busy_o, // Busy
    input wire logic [NCH-1:0] transfer_end_irq, // End interrupt
    input wire logic [NCH-1:0][7:0] irq_vector_number // Vector
);
    // ------------
    // Port relations, channel 0 stands for both
    // ------------
    default clocking dcc_cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_reset_quiet: assert property (reset_n && !$past(reset_n) |->
        busy_o == '0 && transfer_end_irq == '0 && rdata_o == 32'h0) else $error("not idle");
    a_read_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data outside its cycle");
    a_vec_upper: assert property ($past(rd_i) && $past(addr_i[3:0]) == 4'h4 |->
        rdata_o[31:8] == 24'h0) else $error("vector upper bits set");
    a_vec_gated: assert property (!transfer_end_irq[0] |-> irq_vector_number[0] == 8'h00)
        else $error("vector without interrupt");
    // Interrupt only rises from a finished transfer or a register write
    a_irq_rise: assert property ($rose(transfer_end_irq[0]) |->
        $past(busy_o[0], 2) || $past(wr_i, 2)) else $error("interrupt without cause");
    a_irq_fall: assert property ($fell(transfer_end_irq[0]) |->
        $past(wr_i, 2) || $past(standby_i, 2)) else $error("interrupt dropped alone");
    a_standby_idle: assert property (standby_i |-> ##2 busy_o == '0)
        else $error("busy after standby");
    a_abort_idle: assert property (nmi_i || addr_err_i |-> ##2 busy_o == '0)
        else $error("busy after abort");
    a_dir_cause: assert property ($changed(xfer_dev_to_mem_o) |->
        $past(wr_i, 2) || $past(standby_i, 2)) else $error("direction changed alone");

    c_end: cover property ($rose(transfer_end_irq[0]));
    c_pin: cover property ($rose(busy_o[1]));
    c_abort: cover property (busy_o[0] && nmi_i);
endmodule : dcc_checker

bind dcc_top dcc_checker #(.NCH(NCH)) dcc_checker_inst (.clk(clk), .reset_n(reset_n),
    .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .nmi_i(nmi_i), .addr_err_i(addr_err_i),
    .transfer_request_in(transfer_request_in), .transfer_ack(transfer_ack),
    .xfer_dev_to_mem_o(xfer_dev_to_mem_o), .busy_o(busy_o),
    .transfer_end_irq(transfer_end_irq), .irq_vector_number(irq_vector_number));

// ===== tb/dcc_req_model.sv
`timescale 1ns/1ps
module dcc_req_model
    import dcc_pkg::*;
#(
    parameter int SLOW = 3 // Delay when answering slowly
) (
    input wire logic clk, // Clock
    input wire logic reset_n, // Reset, active low
    input wire logic go, // Device wants service
    input wire logic hi, // Active level of the request
    input wire logic slow, // Answer late
    output logic req // Request pin
);
    logic [3:0] wait_r; // Cycles since go
    // Saturating, so a long service need does not wrap
    always_ff @(posedge clk) begin
        if (!reset_n || !go) begin
            wait_r <= 4'h0;
        end else if (wait_r != 4'hf) begin
            wait_r <= wait_r + 4'h1;
        end
    end
    // Push-pull pin: idle level whenever no service is wanted
    assign req = (go && (!slow || wait_r >= 4'(SLOW))) ? hi : ~hi;
endmodule : dcc_req_model

// ===== tb/test_dcc_top.sv
`timescale 1ns/1ps
module test_dcc_top
    import dcc_pkg::*;
    ;
    logic clk, reset_n, standby_i, wr_i, rd_i, nmi_i, addr_err_i, rd_seen;
    logic [7:0] addr_i, vec; // Bus address, chosen vector
    logic [31:0] wdata_i, rdata_o, c, n; // Bus data, control word, count
    logic [1:0] transfer_request_in, transfer_ack, xfer_dev_to_mem_o, busy_o, transfer_end_irq;
    logic [1:0] go, hi, slow, lvl; // Device controls, ack active level
    logic [1:0][7:0] irq_vector_number;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    logic [7:0] ra[6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h0c}; // Reset-value reads
    int num_errors, checks, cycles, acks[2], a0;

    dcc_top #(.NCH(2)) dcc_top_inst (.clk(clk), .reset_n(reset_n), .standby_i(standby_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .nmi_i(nmi_i), .addr_err_i(addr_err_i), .transfer_request_in(transfer_request_in),
        .transfer_ack(transfer_ack), .xfer_dev_to_mem_o(xfer_dev_to_mem_o), .busy_o(busy_o),
        .transfer_end_irq(transfer_end_irq), .irq_vector_number(irq_vector_number));
    for (genvar g = 0; g < 2; g++) begin : g_dev
        dcc_req_model dcc_req_model_inst (.clk(clk), .reset_n(reset_n), .go(go[g]),
            .hi(hi[g]), .slow(slow[g]), .req(transfer_request_in[g]));
    end

    // ------------
    // Bus tasks and comparison
    // ------------
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge clk);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge clk);
        {rd_i, addr_i} <= {1'b1, a};
        exp_q.push_back(e);
        @(posedge clk);
        rd_i <= 1'b0;
    endtask : rd
    task automatic wait_irq(int ch);
        for (int i = 0; i < 400 && transfer_end_irq[ch] !== 1'b1; i++) begin
            @(posedge clk);
        end
        check("end interrupt", transfer_end_irq[ch], 1'b1);
    endtask : wait_irq
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // ------------
    // Clock and monitor
    // ------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Counts use non-blocking updates so snapshots never race
    always @(posedge clk) begin
        if (rd_seen === 1'b1) begin
            check("read data", rdata_o, exp_q.pop_front());
        end
        rd_seen <= rd_i;
        acks[0] <= acks[0] + int'(transfer_ack[0] === lvl[0]);
        acks[1] <= acks[1] + int'(transfer_ack[1] === lvl[1]);
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            num_errors++;
            finish_test();
        end
    end

    // ------------
    // Main sequence
    // ------------
    initial begin
        {reset_n, standby_i, wr_i, rd_i, nmi_i, addr_err_i, rd_seen} = '0;
        {addr_i, wdata_i, go, hi, slow, lvl} = '0;
        {num_errors, checks, cycles, acks[0], acks[1]} = '0;
        void'($urandom(86));
        vec = 8'($urandom_range(127, 0));
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], 32'h0);
        wr(8'h04, {24'h0, vec});
        wr(8'h14, {24'h0, 8'h7f ^ vec});
        rd(8'h04, {24'h0, vec});
        rd(8'h14, {24'h0, 8'h7f ^ vec});
        wr(8'h20, 32'h1);
        $display("test registers done");
        // Auto transfers, every size; destinations never internal memory
        for (int sz = 0; sz < 4; sz++) begin
            n = 32'(4 * $urandom_range(2, 1));
            c = {20'h0, 2'(sz), 1'b1, 2'($urandom), 2'b10, 2'($urandom), 1'b1, 2'b01};
            lvl[0] <= c[7];
            wr(8'h08, n);
            wr(8'h00, c & ~32'h1);
            repeat (2) @(posedge clk);
            a0 = acks[0];
            wr(8'h00, c);
            wait_irq(0);
            repeat (2) @(posedge clk);
            check("ack count", 32'(acks[0] - a0), n);
            check("vector", {24'h0, irq_vector_number[0]}, {24'h0, vec});
            check("direction", {31'h0, xfer_dev_to_mem_o[0]}, {31'h0, c[3] & c[8]});
            rd(8'h08, 32'h0);
            rd(8'h00, c | 32'h2);
            wr(8'h00, c | 32'h2);
            repeat (5) @(posedge clk);
            check("busy", busy_o[0], 1'b0);
            wr(8'h00, c & ~32'h1);
            rd(8'h00, c & ~32'h1 | 32'h2);
            wr(8'h00, c & ~32'h1);
            rd(8'h00, c & ~32'h1);
            check("end interrupt", transfer_end_irq[0], 1'b0);
            $display("test size %0d done", sz);
        end
        // Pin requests: level with cycle steal, edge with burst, both levels
        for (int m = 0; m < 4; m++) begin
            n = 32'($urandom_range(3, 1));
            c = {20'h0, 2'($urandom_range(2)), 1'b0, 2'($urandom), 2'(m), m[1], 4'h5};
            {hi[1], slow[1], lvl[1]} <= {1'(m), 1'($urandom), c[7]};
            wr(8'h18, n);
            wr(8'h10, c & ~32'h1);
            repeat (2) @(posedge clk);
            a0 = acks[1];
            wr(8'h10, c);
            repeat (6) @(posedge clk);
            check("busy", busy_o[1], 1'b0);
            go[1] <= 1'b1;
            wait_irq(1);
            go[1] <= 1'b0;
            repeat (2) @(posedge clk);
            check("ack count", 32'(acks[1] - a0), n);
            rd(8'h18, 32'h0);
            rd(8'h10, c | 32'h2);
            wr(8'h10, c & ~32'h1);
            $display("test request mode %0d done", m);
        end
        // Stops in mid-run: abort, address error, enable cleared, standby
        for (int k = 0; k < 4; k++) begin
            c = 32'h0000_0205;
            wr(8'h08, 32'h0000_00c8);
            wr(8'h00, c);
            repeat (20) @(posedge clk);
            check("busy", busy_o[0], 1'b1);
            if (k == 2) begin
                wr(8'h00, 32'h4);
            end else begin
                {nmi_i, addr_err_i, standby_i} <= {k == 0, k == 1, k == 3};
                @(posedge clk);
                {nmi_i, addr_err_i, standby_i} <= 3'h0;
            end
            repeat (3) @(posedge clk);
            check("busy", busy_o[0], 1'b0);
            rd(8'h00, k == 3 ? 32'h0 : (k == 2 ? 32'h4 : c));
            if (k < 3) begin
                rd(8'h20, k < 2 ? 32'h1 | (32'h2 << k) : 32'h1);
            end
            wr(8'h00, 32'h0);
            wr(8'h20, 32'h1);
            check("end interrupt", transfer_end_irq[0], 1'b0);
            $display("test stop %0d done", k);
        end
        rd(8'h04, {24'h0, vec});
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h14, {24'h0, 8'h7f ^ vec});
        rd(8'h20, 32'h0);
        repeat (3) @(posedge clk);
        $display("test second reset done");
        finish_test();
    end
endmodule : test_dcc_top
